// File: rtl/blx_alu.sv
// ALU: byte-oriented and literal results with zero detect
`timescale 1ns/1ps
module blx_alu
  import blx_pkg::*;
(
  blx_alu_if.alu a
);
  // Op code 4'hF selects the literal OR path
  always_comb begin
    case (a.op)
      BYTE_DEC: a.result = a.f_val - 8'h01;
      BYTE_IOR: a.result = a.w_val | a.f_val;
      BYTE_MOV: a.result = a.f_val;
      BYTE_COM: a.result = ~a.f_val;
      4'hF:     a.result = a.w_val | a.lit;
      default:  a.result = a.f_val;
    endcase
  end
  assign a.zero = (a.result == 8'h00);
endmodule

// File: rtl/blx_alu_if.sv
// Interface: operands and result between decoder and ALU
`timescale 1ns/1ps
interface blx_alu_if;
  import blx_pkg::*;
  logic [3:0]        op;
  logic [DATA_W-1:0] w_val;
  logic [DATA_W-1:0] f_val;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] result;
  logic              zero;
  modport ctl (output op, output w_val, output f_val, output lit,
               input result, input zero);
  modport alu (input op, input w_val, input f_val, input lit,
               output result, output zero);
endinterface

// File: rtl/blx_executor.sv
// Top: decode and execute of the bit, byte and watchdog-clear subset
`timescale 1ns/1ps
module blx_executor
  import blx_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               resetn_i,
  input  wire logic               instr_valid_i,
  input  wire logic [INSTR_W-1:0] instr_i,
  input  wire logic [DATA_W-1:0]  rf_rdata_i,
  input  wire logic               wdog_tick_i,
  input  wire logic               wdog_expire_clr_i,
  input  wire logic               sleep_enter_i,
  output logic      [ADDR_W-1:0]  rf_addr_o,
  output logic                    rf_we_o,
  output logic      [DATA_W-1:0]  rf_wdata_o,
  output logic      [DATA_W-1:0]  w_o,
  output logic                    zero_flag_o,
  output logic                    watchdog_expiry_bit_o,
  output logic                    sleep_entry_bit_o,
  output logic      [WDOG_W-1:0]  wdog_count_o,
  output logic      [PRESC_W-1:0] wdog_presc_o,
  output logic                    skip_o
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [1:0]           grp;
  logic [3:0]           sub;
  logic [BIT_SEL_W-1:0] bsel;
  logic                 dbit;
  logic [DATA_W-1:0]    bmask;
  logic                 bit_clear_op;
  logic                 bit_set_op;
  logic                 bit_test_skip_clear_op;
  logic                 complement_op;
  logic                 decrement_op;
  logic                 or_literal_op;
  logic                 or_register_op;
  logic                 move_register_op;
  logic                 watchdog_clear_op;
  logic                 byte_op;
  logic                 exec;
  logic                 skip_q;
  logic                 skip_d;

  // A skipped slot is executed as a no-op, so nothing below acts on it
  assign exec = instr_valid_i & ~skip_q;
  assign grp  = instr_i[13:12];
  assign sub  = instr_i[11:8];
  assign bsel = instr_i[BIT_SEL_LSB +: BIT_SEL_W];
  assign dbit = instr_i[DEST_BIT];
  assign bmask = 8'h01 << bsel;

  assign bit_clear_op  = exec & (grp == GRP_BIT) & (sub[3:2] == BIT_CLR);
  assign bit_set_op    = exec & (grp == GRP_BIT) & (sub[3:2] == BIT_SET);
  assign bit_test_skip_clear_op =
    exec & (grp == GRP_BIT) & (sub[3:2] == BIT_TSTC);
  assign complement_op    = exec & (grp == GRP_BYTE) & (sub == BYTE_COM);
  assign decrement_op     = exec & (grp == GRP_BYTE) & (sub == BYTE_DEC);
  assign or_register_op   = exec & (grp == GRP_BYTE) & (sub == BYTE_IOR);
  assign move_register_op = exec & (grp == GRP_BYTE) & (sub == BYTE_MOV);
  assign or_literal_op    = exec & (grp == GRP_LIT) & (sub == LIT_IOR);
  assign watchdog_clear_op = exec & (instr_i == WDOG_CLR);
  assign byte_op = complement_op | decrement_op | or_register_op
                 | move_register_op;

  // ****************************************************************
  // ALU
  // ****************************************************************
  blx_alu_if alu_bus ();
  assign alu_bus.op    = or_literal_op ? 4'hF : sub;
  assign alu_bus.w_val = w_o;
  assign alu_bus.f_val = rf_rdata_i;
  assign alu_bus.lit   = instr_i[DATA_W-1:0];

  blx_alu u_alu (
    .a (alu_bus.alu)
  );

  // ****************************************************************
  // Register file port
  // ****************************************************************
  // Read data is combinational from the file for the same address
  assign rf_addr_o = instr_i[ADDR_W-1:0];

  always_comb begin
    rf_we_o    = 1'b0;
    rf_wdata_o = rf_rdata_i;
    if (bit_clear_op) begin
      rf_we_o    = 1'b1;
      rf_wdata_o = rf_rdata_i & ~bmask;
    end else if (bit_set_op) begin
      rf_we_o    = 1'b1;
      rf_wdata_o = rf_rdata_i | bmask;
    end else if (byte_op && dbit) begin
      rf_we_o    = 1'b1;
      rf_wdata_o = alu_bus.result;
    end
  end

  // ****************************************************************
  // Working register, zero flag, skip
  // ****************************************************************
  logic [DATA_W-1:0] w_q;
  logic [DATA_W-1:0] w_d;
  logic              z_q;
  logic              z_d;

  always_comb begin
    w_d    = w_q;
    z_d    = z_q;
    skip_d = 1'b0;
    if (byte_op) begin
      z_d = alu_bus.zero;
      if (!dbit) begin
        w_d = alu_bus.result;
      end
    end else if (or_literal_op) begin
      w_d = alu_bus.result;
      z_d = alu_bus.zero;
    end
    if (bit_test_skip_clear_op) begin
      skip_d = ~|(rf_rdata_i & bmask);
    end else if (skip_q) begin
      skip_d = ~instr_valid_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      w_q    <= W_RESET;
      z_q    <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      w_q    <= w_d;
      z_q    <= z_d;
      skip_q <= skip_d;
    end
  end

  assign w_o         = w_q;
  assign zero_flag_o = z_q;
  assign skip_o      = skip_q;

  // ****************************************************************
  // Watchdog counter, prescaler and status bits
  // ****************************************************************
  logic [WDOG_W-1:0]  cnt_q;
  logic [WDOG_W-1:0]  cnt_d;
  logic [PRESC_W-1:0] pre_q;
  logic [PRESC_W-1:0] pre_d;
  logic               expiry_q;
  logic               expiry_d;
  logic               sleep_q;
  logic               sleep_d;

  always_comb begin
    cnt_d = cnt_q;
    pre_d = pre_q;
    expiry_d = expiry_q;
    sleep_d  = sleep_q;
    if (wdog_tick_i) begin
      pre_d = pre_q + 8'h01;
      if (pre_q == 8'hFF) begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    if (wdog_expire_clr_i) begin
      expiry_d = 1'b0;
    end
    if (sleep_enter_i) begin
      sleep_d = 1'b0;
    end
    // Clear instruction overrides ticks and outside clears
    if (watchdog_clear_op) begin
      cnt_d    = 8'h00;
      pre_d    = 8'h00;
      expiry_d = 1'b1;
      sleep_d  = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cnt_q <= 8'h00;
      pre_q <= 8'h00;
      expiry_q <= 1'b1;
      sleep_q  <= 1'b1;
    end else begin
      cnt_q    <= cnt_d;
      pre_q    <= pre_d;
      expiry_q <= expiry_d;
      sleep_q  <= sleep_d;
    end
  end

  assign wdog_count_o          = cnt_q;
  assign wdog_presc_o          = pre_q;
  assign watchdog_expiry_bit_o = expiry_q;
  assign sleep_entry_bit_o     = sleep_q;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Literals above are byte wide; other widths need a rework
  if (DATA_W != 8 || WDOG_W != 8 || PRESC_W != 8) begin : g_width_chk
    $error("executor supports byte-wide data and watchdog only");
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  chk_bclr_bit: assert property (bit_clear_op |->
    rf_we_o && !rf_wdata_o[bsel] ##1 $stable(z_q))
    else $error("bit clear wrong");
  chk_bset_bit: assert property (bit_set_op |->
    rf_we_o && rf_wdata_o[bsel] ##1 $stable(z_q))
    else $error("bit set wrong");
  sequence s_skip_taken;
    bit_test_skip_clear_op && !rf_rdata_i[bsel];
  endsequence
  chk_skip_slot: assert property (s_skip_taken |=>
    skip_q && !rf_we_o && $stable(w_q) ##1 $stable(w_q) && $stable(z_q))
    else $error("skip slot not a no-op");
  chk_dest_sel: assert property (byte_op && !dbit |->
    !rf_we_o ##1 w_q == $past(alu_bus.result))
    else $error("destination W wrong");
  chk_com_val: assert property (complement_op && dbit |->
    rf_wdata_o == ~rf_rdata_i)
    else $error("complement wrong");
  chk_dec_val: assert property (decrement_op && dbit |->
    rf_wdata_o == rf_rdata_i - 8'h01)
    else $error("decrement wrong");
  chk_iorl_w: assert property (or_literal_op |=>
    w_q == ($past(w_q) | $past(instr_i[7:0])))
    else $error("or literal wrong");
  chk_iorf_val: assert property (or_register_op && dbit |->
    rf_wdata_o == (w_q | rf_rdata_i))
    else $error("or register wrong");
  chk_mov_zero: assert property (move_register_op |=>
    z_q == ($past(rf_rdata_i) == 8'h00))
    else $error("move zero flag wrong");
  chk_wdog_clr: assert property (watchdog_clear_op |=>
    cnt_q == 8'h00 && pre_q == 8'h00 && expiry_q && sleep_q)
    else $error("watchdog clear wrong");
  chk_zero_flag: assert property (byte_op || or_literal_op |=>
    z_q == ($past(alu_bus.result) == 8'h00))
    else $error("zero flag wrong");

  // Bit-op side effects, skip handling, and results into W checked from the operands rather than the ALU
  chk_bit_others: assert property (bit_clear_op || bit_set_op |->
    ((rf_wdata_o ^ rf_rdata_i) & ~bmask) == 8'h00)
    else $error("bit op touched other bits");
  chk_bit_w_keep: assert property (bit_set_op || bit_clear_op |=>
    $stable(w_q) && $stable(z_q))
    else $error("bit op changed W or zero");
  sequence s_slot_dropped;
    skip_q && instr_valid_i;
  endsequence
  chk_skip_end: assert property (s_slot_dropped |=> !skip_q)
    else $error("skip not cleared by dropped slot");
  chk_skip_wait: assert property (
    skip_q && !instr_valid_i |=> skip_q)
    else $error("skip lost without a slot");
  chk_no_skip: assert property (
    bit_test_skip_clear_op && rf_rdata_i[bsel] |=> !skip_q)
    else $error("skip taken on a set bit");
  chk_idle_quiet: assert property (!exec |-> !rf_we_o)
    else $error("write from a discarded slot");
  chk_dest_file: assert property (byte_op && dbit |->
    rf_we_o ##1 $stable(w_q))
    else $error("destination file wrong");
  chk_com_w: assert property (complement_op && !dbit |=>
    w_q == ~$past(rf_rdata_i))
    else $error("complement to W wrong");
  chk_dec_w: assert property (decrement_op && !dbit |=>
    w_q == $past(rf_rdata_i) - 8'h01)
    else $error("decrement to W wrong");
  chk_iorl_zero: assert property (or_literal_op |=>
    z_q == (w_q == 8'h00))
    else $error("or literal zero flag wrong");
  chk_iorf_w: assert property (or_register_op && !dbit |=>
    w_q == ($past(w_q) | $past(rf_rdata_i)))
    else $error("or register to W wrong");
  chk_mov_w: assert property (move_register_op && !dbit |=>
    w_q == $past(rf_rdata_i))
    else $error("move to W wrong");
  chk_wdog_keep: assert property (watchdog_clear_op |->
    !rf_we_o ##1 $stable(w_q) && $stable(z_q))
    else $error("watchdog clear touched core state");
endmodule

// File: rtl/blx_pkg.sv
// Package: opcode patterns, field positions, widths and reset value for the executor
package blx_pkg;
  localparam int         INSTR_W      = 14;
  localparam int         DATA_W       = 8;
  localparam int         ADDR_W       = 7;
  localparam int         BIT_SEL_LSB  = 7;
  localparam int         BIT_SEL_W    = 3;
  localparam int         DEST_BIT     = 7;
  localparam logic [1:0] GRP_BYTE     = 2'h0;
  localparam logic [1:0] GRP_BIT      = 2'h1;
  localparam logic [1:0] GRP_LIT      = 2'h3;
  localparam logic [1:0] BIT_CLR      = 2'h0;
  localparam logic [1:0] BIT_SET      = 2'h1;
  localparam logic [1:0] BIT_TSTC     = 2'h2;
  localparam logic [3:0] BYTE_DEC     = 4'h3;
  localparam logic [3:0] BYTE_IOR     = 4'h4;
  localparam logic [3:0] BYTE_MOV     = 4'h8;
  localparam logic [3:0] BYTE_COM     = 4'h9;
  localparam logic [3:0] LIT_IOR      = 4'h8;
  localparam logic [13:0] WDOG_CLR    = 14'h0064;
  localparam logic [7:0] W_RESET      = 8'h00;
  localparam int         WDOG_W       = 8;
  localparam int         PRESC_W      = 8;
  typedef enum logic [1:0] {
    BLX_NONE,
    BLX_W,
    BLX_F
  } blx_dest_t;
endpackage

// File: verification/blx_executor_test.sv
// Self-checking bench for the bit, byte and watchdog-clear executor
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module blx_executor_test;
  import blx_pkg::*;
  logic               clock_i = 1'b0;
  logic               resetn_i = 1'b0;
  logic               instr_valid_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic               wdog_tick_i = 1'b0;
  logic               wdog_expire_clr_i = 1'b0;
  logic               sleep_enter_i = 1'b0;
  logic [DATA_W-1:0]  rf_rdata_i, rf_wdata_o, w_o, ew, v, r;
  logic [ADDR_W-1:0]  rf_addr_o;
  logic               rf_we_o, zero_flag_o, skip_o, zf, d;
  logic               watchdog_expiry_bit_o, sleep_entry_bit_o;
  logic [WDOG_W-1:0]  wdog_count_o;
  logic [PRESC_W-1:0] wdog_presc_o;
  logic [3:0]         op;
  logic [3:0]         ops [4] = '{BYTE_DEC, BYTE_IOR, BYTE_MOV, BYTE_COM};
  logic [7:0]         vals [4] = '{8'h01, 8'h40, 8'h00, 8'h5A};
  int                 n_fail = 0;
  int                 cmp_count = 0;

  always #10 clock_i = ~clock_i;

  blx_executor DUT (
    .clock_i               (clock_i),
    .resetn_i              (resetn_i),
    .instr_valid_i         (instr_valid_i),
    .instr_i               (instr_i),
    .rf_rdata_i            (rf_rdata_i),
    .wdog_tick_i           (wdog_tick_i),
    .wdog_expire_clr_i     (wdog_expire_clr_i),
    .sleep_enter_i         (sleep_enter_i),
    .rf_addr_o             (rf_addr_o),
    .rf_we_o               (rf_we_o),
    .rf_wdata_o            (rf_wdata_o),
    .w_o                   (w_o),
    .zero_flag_o           (zero_flag_o),
    .watchdog_expiry_bit_o (watchdog_expiry_bit_o),
    .sleep_entry_bit_o     (sleep_entry_bit_o),
    .wdog_count_o          (wdog_count_o),
    .wdog_presc_o          (wdog_presc_o),
    .skip_o                (skip_o)
  );

  blx_rf_model u_rf (
    .clock_i (clock_i),
    .addr_i  (rf_addr_o),
    .we_i    (rf_we_o),
    .wdata_i (rf_wdata_o),
    .rdata_o (rf_rdata_i)
  );

  // Valid stays up on return so calls can run back to back
  task automatic exec(input logic [INSTR_W-1:0] ins);
    instr_i = ins;
    instr_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
  endtask

  task automatic idle();
    instr_valid_i = 1'b0;
    @(posedge clock_i);
    #1;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clock_i);
    #1;
    `CHK({w_o, zero_flag_o, skip_o, watchdog_expiry_bit_o, sleep_entry_bit_o,
          wdog_count_o, wdog_presc_o}, {8'h00, 4'h3, 16'h0000})
    resetn_i = 1'b1;
    exec({GRP_LIT, LIT_IOR, 8'h00});
    `CHK({w_o, zero_flag_o}, {8'h00, 1'b1})
    exec({GRP_LIT, LIT_IOR, 8'h9A});
    `CHK({w_o, zero_flag_o}, {8'h9A, 1'b0})
    exec({GRP_LIT, LIT_IOR, 8'h35});
    `CHK({w_o, zero_flag_o}, {8'hBF, 1'b0})
    ew = 8'hBF;
    for (int i = 0; i < 8; i++) begin
      op = ops[i % 4];
      v = vals[i % 4];
      d = (i >= 4);
      u_rf.mem[7'h10] = v;
      r = (op == BYTE_DEC) ? v - 8'h01 : (op == BYTE_IOR) ? (ew | v) :
          (op == BYTE_MOV) ? v : ~v;
      exec({GRP_BYTE, op, d, 7'h10});
      if (d == 1'b0) begin
        ew = r;
      end
      `CHK(zero_flag_o, r == 8'h00)
      `CHK(w_o, ew)
      `CHK(u_rf.mem[7'h10], d ? r : v)
    end
    for (int b = 0; b < 8; b++) begin
      u_rf.mem[7'h21] = 8'hFF;
      u_rf.mem[7'h22] = 8'h00;
      zf = zero_flag_o;
      exec({GRP_BIT, BIT_CLR, b[2:0], 7'h21});
      `CHK({u_rf.mem[7'h21], zero_flag_o}, {~(8'h01 << b), zf})
      exec({GRP_BIT, BIT_SET, b[2:0], 7'h22});
      `CHK({u_rf.mem[7'h22], zero_flag_o}, {8'h01 << b, zf})
    end
    u_rf.mem[7'h30] = 8'hF7;
    exec({GRP_BIT, BIT_TSTC, 3'h3, 7'h30});
    `CHK(skip_o, 1'b1)
    exec({GRP_LIT, LIT_IOR, 8'hFF});
    `CHK({skip_o, w_o}, {1'b0, ew})
    exec({GRP_BIT, BIT_TSTC, 3'h4, 7'h30});
    `CHK(skip_o, 1'b0)
    exec({GRP_LIT, LIT_IOR, 8'h5A});
    ew = ew | 8'h5A;
    `CHK(w_o, ew)
    idle();
    wdog_tick_i = 1'b1;
    // 300 ticks: one prescaler wrap, then 44 more
    repeat (300) @(posedge clock_i);
    #1;
    wdog_tick_i = 1'b0;
    wdog_expire_clr_i = 1'b1;
    sleep_enter_i = 1'b1;
    idle();
    `CHK({wdog_count_o, wdog_presc_o, watchdog_expiry_bit_o,
          sleep_entry_bit_o}, {8'h01, 8'h2C, 2'h0})
    exec(WDOG_CLR);
    `CHK({wdog_count_o, wdog_presc_o, watchdog_expiry_bit_o,
          sleep_entry_bit_o}, {16'h0000, 2'h3})
    wdog_expire_clr_i = 1'b0;
    sleep_enter_i = 1'b0;
    idle();
    summarize();
  end

  initial begin
    #50000;
    n_fail++;
    $display("ERROR %0t timeout", $time);
    summarize();
  end
endmodule

// File: verification/blx_rf_model.sv
// Model of the data register file on the executor's far side
`timescale 1ns/1ps
module blx_rf_model
  import blx_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              we_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  // Same-cycle read, since the core operates on the value at once
  assign rdata_o = mem[addr_i];
  always @(posedge clock_i) begin
    if (we_i === 1'b1) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule
